// ### common/scsm_cfg.svh
// Register indices, field positions and reset values of the capture monitor.
// Assumes a 32-bit bus where the byte address of a register is four times its index.
`ifndef SCSM_CFG_SVH
`define SCSM_CFG_SVH
// ----------------------------------------
// Register indices
// ----------------------------------------
`define SCSM_IDX_CTRL1 9'h120
`define SCSM_IDX_CTRL4 9'h123
`define SCSM_IDX_SH_STAT 9'h128
`define SCSM_IDX_PH_STAT 9'h129
`define SCSM_IDX_EVT_CNT 9'h12a
`define SCSM_IDX_SYNC 9'h1ff
// ----------------------------------------
// Field positions
// ----------------------------------------
`define SCSM_CNT_CLR_BIT 6
`define SCSM_MODE_LSB 1
`define SCSM_MODE_MSB 2
`define SCSM_TSTAMP_BIT 0
`define SCSM_DELAY_MSB 6
`define SCSM_IDX_LSB 2
`define SCSM_IDX_MSB 10
// ----------------------------------------
// Reset values
// ----------------------------------------
`define SCSM_RST_BYTE 8'h00
`define SCSM_RST_DELAY 7'h00
`define SCSM_RST_NIB 4'h0
`define SCSM_RST_WORD 32'h0000_0000
`endif

// ### common/scsm_pkg.sv
// Types shared by the capture monitor modules.
// Assumes the constants header is included by each design file.
package scsm_pkg;
  typedef enum logic [1:0] {
    mode_off = 2'h0,
    mode_cont = 2'h1,
    mode_nshot = 2'h2,
    mode_rsvd = 2'h3
  } scsm_sref_mode_t;

  typedef enum logic [2:0] {
    st_idle = 3'h1,
    st_wr = 3'h2,
    st_rd = 3'h4
  } scsm_bus_st_t;
endpackage

// ### common/scsm_cap_if.sv
// Carries the capture pulse, its delayed copy and the delay tap between modules.
// Assumes all three parties run on the same sample clock.
`timescale 1ns/1ps
interface scsm_cap_if;
  logic cap_pulse;
  logic armed;
  logic [6:0] tap;
  logic delayed_pulse;
  modport src (output cap_pulse, input armed);
  modport dly (input cap_pulse, input tap, output delayed_pulse);
  modport core (input cap_pulse, input delayed_pulse, output armed, output tap);
endinterface

// ### design/scsm_edge_capture.sv
// Synchronises the reference pin and turns each rising edge into a capture pulse while armed.
// Assumes the pin is asynchronous to ref_clk and held high for at least two cycles.
`timescale 1ns/1ps
`include "scsm_cfg.svh"
module scsm_edge_capture import scsm_pkg::*; (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic sysref_in,
  scsm_cap_if.src cap
);
  logic meta_ff;
  logic sync_ff;
  logic prev_ff;
  logic pulse_ff;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
      prev_ff <= 1'b0;
    end else begin
      meta_ff <= sysref_in;
      sync_ff <= meta_ff;
      prev_ff <= sync_ff;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      pulse_ff <= 1'b0;
    end else begin
      pulse_ff <= sync_ff & ~prev_ff & cap.armed;
    end
  end

  assign cap.cap_pulse = pulse_ff;
endmodule

// ### design/scsm_delay_line.sv
// Delays the capture pulse by a programmable number of sample clock cycles.
// Assumes the tap is steady while a pulse is in flight.
`timescale 1ns/1ps
`include "scsm_cfg.svh"
module scsm_delay_line import scsm_pkg::*; #(
  parameter int DLY_DEPTH = 127
) (
  input wire logic ref_clk,
  input wire logic resetn,
  scsm_cap_if.dly cap
);
  logic [DLY_DEPTH-1:0] sr_ff;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      sr_ff <= '0;
    end else begin
      sr_ff <= {sr_ff[DLY_DEPTH-2:0], cap.cap_pulse};
    end
  end

  // Tap n takes the pulse n cycles late; tap 0 passes it straight through
  assign cap.delayed_pulse = (cap.tap == 7'h00) ? cap.cap_pulse : sr_ff[cap.tap - 7'h01];

  default clocking dcb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  AST_TAP_ZERO: assert property ((cap.tap == 7'h00) |-> (cap.delayed_pulse == cap.cap_pulse))
    else $error("tap zero does not pass the pulse through");
  AST_TAP_ONE: assert property ((cap.cap_pulse && cap.tap == 7'h01) ##1 (cap.tap == 7'h01)
    |-> cap.delayed_pulse)
    else $error("tap one does not delay by one cycle");
endmodule

// ### design/scsm_top.sv
// Reference capture monitor: AHB-Lite registers, divider, event count and timestamp tag.
// Assumes one AHB-Lite master, a free-running ref_clk and an asynchronous reference pin.
//
// Summary of operation
// - A seven-bit delay in sample clocks is applied to the capture timestamp.
// - Delay value n gives exactly n sample clock cycles of delay, up to 127.
// - Hold status sits in the upper nibble, setup in the lower; both reset to zero.
// - Each capture stores the divider phase as a four-bit read-only code.
// - Phase code counts lag in half input-clock steps, zero meaning in phase.
// - An eight-bit counter increments by one on every capture while the counter-reset bit is clear.
// - The event counter wraps from 255 to zero instead of saturating.
// - The counter-reset control bit clears the event counter.
// - With sync mode bit zero, each capture resets all internal dividers.
// - In that mode a capture that moves a divider phase drops the link.
// - With sync mode bit one, captures leave the dividers untouched.
// - In timestamp mode captures do not touch link state or signal monitor.
// - In timestamp mode the captured sample is tagged by a control bit.
`timescale 1ns/1ps
`include "scsm_cfg.svh"
module scsm_top import scsm_pkg::*; #(
  parameter int SAMPLE_W = 14,
  parameter int DIV_W = 3,
  parameter int DLY_DEPTH = 127
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic sysref_in,
  input wire logic [7:0] sh_window_in,
  input wire logic [SAMPLE_W-1:0] sample_in,
  output logic [SAMPLE_W:0] word_out,
  output logic div_reset,
  output logic link_down,
  output logic sigmon_sync
);
  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  scsm_cap_if cap_if ();

  scsm_bus_st_t st_ff;
  scsm_bus_st_t nxt_st;
  logic [8:0] idx_ff;
  logic [31:0] hrdata_ff;
  logic [31:0] nxt_rdata;
  logic addr_ok;
  logic wr_en;

  logic cnt_clr_ff;
  scsm_sref_mode_t mode_ff;
  logic [6:0] delay_ff;
  logic ts_mode_ff;

  logic [3:0] hold_ff;
  logic [3:0] setup_ff;
  logic [3:0] phase_ff;
  logic [7:0] evt_cnt_ff;
  logic [DIV_W-1:0] div_cnt_ff;

  logic cap;
  logic sync_cap;
  logic div_reset_ff;
  logic link_down_ff;
  logic sigmon_ff;
  logic [SAMPLE_W:0] word_ff;

  // ----------------------------------------
  // Capture path
  // ----------------------------------------
  scsm_edge_capture u_capture (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .sysref_in(sysref_in),
    .cap(cap_if.src)
  );

  scsm_delay_line #(
    .DLY_DEPTH(DLY_DEPTH)
  ) u_delay (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .cap(cap_if.dly)
  );

  assign cap_if.armed = (mode_ff != mode_off);
  assign cap_if.tap = delay_ff;
  assign cap = cap_if.cap_pulse;
  assign sync_cap = cap & ~ts_mode_ff;

  // ----------------------------------------
  // AHB-Lite slave
  // ----------------------------------------
  assign addr_ok = hsel & hready & htrans[1];
  assign wr_en = (st_ff == st_wr);

  always_comb begin
    nxt_st = st_ff;
    if (addr_ok) begin
      nxt_st = hwrite ? st_wr : st_rd;
    end else if (hready) begin
      nxt_st = st_idle;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      st_ff <= st_idle;
    end else begin
      st_ff <= nxt_st;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      idx_ff <= 9'h000;
    end else if (addr_ok) begin
      idx_ff <= haddr[`SCSM_IDX_MSB:`SCSM_IDX_LSB];
    end
  end

  // Read data is fetched in the address phase so it stands from a flop
  always_comb begin
    nxt_rdata = `SCSM_RST_WORD;
    if (haddr[`SCSM_IDX_MSB:`SCSM_IDX_LSB] == `SCSM_IDX_CTRL1) begin
      nxt_rdata[`SCSM_CNT_CLR_BIT] = cnt_clr_ff;
      nxt_rdata[`SCSM_MODE_MSB:`SCSM_MODE_LSB] = mode_ff;
    end else if (haddr[`SCSM_IDX_MSB:`SCSM_IDX_LSB] == `SCSM_IDX_CTRL4) begin
      nxt_rdata[`SCSM_DELAY_MSB:0] = delay_ff;
    end else if (haddr[`SCSM_IDX_MSB:`SCSM_IDX_LSB] == `SCSM_IDX_SH_STAT) begin
      nxt_rdata[7:0] = {hold_ff, setup_ff};
    end else if (haddr[`SCSM_IDX_MSB:`SCSM_IDX_LSB] == `SCSM_IDX_PH_STAT) begin
      nxt_rdata[3:0] = phase_ff;
    end else if (haddr[`SCSM_IDX_MSB:`SCSM_IDX_LSB] == `SCSM_IDX_EVT_CNT) begin
      nxt_rdata[7:0] = evt_cnt_ff;
    end else if (haddr[`SCSM_IDX_MSB:`SCSM_IDX_LSB] == `SCSM_IDX_SYNC) begin
      nxt_rdata[`SCSM_TSTAMP_BIT] = ts_mode_ff;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      hrdata_ff <= `SCSM_RST_WORD;
    end else if (addr_ok && !hwrite) begin
      hrdata_ff <= nxt_rdata;
    end else if (addr_ok) begin
      hrdata_ff <= `SCSM_RST_WORD;
    end
  end

  assign hrdata = hrdata_ff;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // ----------------------------------------
  // Control registers
  // ----------------------------------------
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      cnt_clr_ff <= 1'b0;
      mode_ff <= mode_off;
    end else if (wr_en && idx_ff == `SCSM_IDX_CTRL1) begin
      cnt_clr_ff <= hwdata[`SCSM_CNT_CLR_BIT];
      mode_ff <= scsm_sref_mode_t'(hwdata[`SCSM_MODE_MSB:`SCSM_MODE_LSB]);
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      delay_ff <= `SCSM_RST_DELAY;
    end else if (wr_en && idx_ff == `SCSM_IDX_CTRL4) begin
      delay_ff <= hwdata[`SCSM_DELAY_MSB:0];
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      ts_mode_ff <= 1'b0;
    end else if (wr_en && idx_ff == `SCSM_IDX_SYNC) begin
      ts_mode_ff <= hwdata[`SCSM_TSTAMP_BIT];
    end
  end

  // ----------------------------------------
  // Capture status
  // ----------------------------------------
  // All three fields load on the same pulse so a read sees one event
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      hold_ff <= `SCSM_RST_NIB;
      setup_ff <= `SCSM_RST_NIB;
      phase_ff <= `SCSM_RST_NIB;
    end else if (cap) begin
      hold_ff <= sh_window_in[7:4];
      setup_ff <= sh_window_in[3:0];
      phase_ff <= {div_cnt_ff, 1'b0};
    end
  end

  // Level clear; a capture while the clear bit stands is not counted
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      evt_cnt_ff <= `SCSM_RST_BYTE;
    end else if (cnt_clr_ff) begin
      evt_cnt_ff <= `SCSM_RST_BYTE;
    end else if (cap) begin
      evt_cnt_ff <= evt_cnt_ff + 8'h01;
    end
  end

  // ----------------------------------------
  // Clock divider and link control
  // ----------------------------------------
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      div_cnt_ff <= '0;
    end else if (sync_cap) begin
      // The capture cycle counts as phase zero, so a reference whose period is a
      // multiple of the divider leaves the divider where it was
      div_cnt_ff <= DIV_W'(1);
    end else begin
      div_cnt_ff <= div_cnt_ff + DIV_W'(1);
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      div_reset_ff <= 1'b0;
      link_down_ff <= 1'b0;
      sigmon_ff <= 1'b0;
    end else begin
      div_reset_ff <= sync_cap;
      link_down_ff <= sync_cap && (div_cnt_ff != '0);
      sigmon_ff <= sync_cap;
    end
  end

  assign div_reset = div_reset_ff;
  assign link_down = link_down_ff;
  assign sigmon_sync = sigmon_ff;

  // ----------------------------------------
  // Timestamp tag on the output word
  // ----------------------------------------
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      word_ff <= '0;
    end else begin
      word_ff <= {ts_mode_ff & cap_if.delayed_pulse, sample_in};
    end
  end

  assign word_out = word_ff;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking dcb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  sequence seq_sync_cap;
    cap && !ts_mode_ff;
  endsequence

  sequence seq_ts_cap;
    cap && ts_mode_ff;
  endsequence

  AST_CNT_INC: assert property ((cap && !cnt_clr_ff) |=>
    (evt_cnt_ff == $past(evt_cnt_ff) + 8'h01))
    else $error("event count did not step by one");
  AST_CNT_WRAP: assert property ((cap && !cnt_clr_ff && evt_cnt_ff == 8'hff) |=>
    (evt_cnt_ff == 8'h00))
    else $error("event count did not wrap to zero");
  AST_CNT_CLR: assert property (cnt_clr_ff |=> (evt_cnt_ff == 8'h00))
    else $error("event count not cleared");
  AST_STATUS: assert property (cap |=> (phase_ff == {$past(div_cnt_ff), 1'b0})
    && ({hold_ff, setup_ff} == $past(sh_window_in)))
    else $error("capture status not updated together");
  AST_SH_HOLD: assert property (!cap |=> $stable({hold_ff, setup_ff, phase_ff}))
    else $error("status changed without a capture");
  AST_DIV_RST: assert property (seq_sync_cap |=> div_reset && (div_cnt_ff == DIV_W'(1))
    ##1 (div_cnt_ff == DIV_W'(2)))
    else $error("divider not reset by capture");
  AST_LINK_DROP: assert property ((seq_sync_cap and (div_cnt_ff != '0)) |=> link_down)
    else $error("link not dropped on divider phase change");
  AST_TS_DIV: assert property (seq_ts_cap |=> !div_reset
    && (div_cnt_ff == $past(div_cnt_ff) + DIV_W'(1)))
    else $error("timestamp capture touched the divider");
  AST_TS_LINK: assert property ((link_down || sigmon_sync) |-> !$past(ts_mode_ff))
    else $error("timestamp capture touched link or monitor");
  AST_TAG: assert property ((ts_mode_ff && cap_if.delayed_pulse) |=> word_out[SAMPLE_W])
    else $error("timestamp tag missing from output word");
  AST_NO_TAG: assert property (!ts_mode_ff |=> !word_out[SAMPLE_W])
    else $error("tag set outside timestamp mode");

  // Link, monitor, divider reset and output word behaviour around a capture
  sequence seq_phase_kept;
    cap && !ts_mode_ff && (div_cnt_ff == '0);
  endsequence

  AST_LINK_KEEP: assert property (seq_phase_kept |=> !link_down)
    else $error("link dropped although no divider moved");
  AST_MON_SYNC: assert property (seq_sync_cap |=> sigmon_sync)
    else $error("monitor not resynchronised by capture");
  AST_TS_QUIET: assert property (seq_ts_cap |=> !link_down && !sigmon_sync)
    else $error("timestamp capture reached link or monitor");
  AST_PULSE_ONE: assert property (div_reset |=> !div_reset)
    else $error("divider reset stood longer than one cycle");
  AST_TAG_SAMPLE: assert property ($past(resetn) |->
    (word_out[SAMPLE_W-1:0] == $past(sample_in)))
    else $error("output word lost its sample");

  // Register writes and reads
  AST_WR_DELAY: assert property ((wr_en && idx_ff == `SCSM_IDX_CTRL4) |=>
    (delay_ff == $past(hwdata[`SCSM_DELAY_MSB:0])))
    else $error("delay write did not land");
  AST_WR_CLR: assert property ((wr_en && idx_ff == `SCSM_IDX_CTRL1) |=>
    (cnt_clr_ff == $past(hwdata[`SCSM_CNT_CLR_BIT])))
    else $error("counter clear write did not land");
  AST_WR_SYNC: assert property ((wr_en && idx_ff == `SCSM_IDX_SYNC) |=>
    (ts_mode_ff == $past(hwdata[`SCSM_TSTAMP_BIT])))
    else $error("sync mode write did not land");
  AST_CNT_IDLE: assert property ((!cap && !cnt_clr_ff) |=> $stable(evt_cnt_ff))
    else $error("event count moved without a capture");
  AST_RD_STAT: assert property ((addr_ok && !hwrite
    && haddr[`SCSM_IDX_MSB:`SCSM_IDX_LSB] == `SCSM_IDX_SH_STAT)
    |=> (hrdata[7:0] == $past({hold_ff, setup_ff})))
    else $error("status read does not return the status byte");
  AST_RD_PHASE: assert property ((addr_ok && !hwrite
    && haddr[`SCSM_IDX_MSB:`SCSM_IDX_LSB] == `SCSM_IDX_PH_STAT)
    |=> (hrdata[3:0] == $past(phase_ff)))
    else $error("phase read does not return the phase code");
  AST_RD_CNT: assert property ((addr_ok && !hwrite
    && haddr[`SCSM_IDX_MSB:`SCSM_IDX_LSB] == `SCSM_IDX_EVT_CNT)
    |=> (hrdata[7:0] == $past(evt_cnt_ff)))
    else $error("count read does not return the event count");
endmodule

// ### tb/scsm_sref_gen.sv
// Model of the external clock source that drives the reference pin.
// Assumes fire is driven just after a rising edge of ref_clk.
`timescale 1ns/1ps
module scsm_sref_gen (
  input wire logic ref_clk,
  input wire logic fire,
  input wire logic [3:0] hi_len,
  output logic sysref_out
);
  int left = 0;

  initial sysref_out = 1'b0;

  // ----------------------------------------
  // Pulse shaping
  // ----------------------------------------
  // High for hi_len cycles (at least 2), then low for 3 before the next pulse
  always @(posedge ref_clk) begin
    if (left == 0 && fire === 1'b1) begin
      sysref_out <= 1'b1;
      left <= ((hi_len < 4'h2) ? 2 : int'(hi_len)) + 2;
    end else if (left != 0) begin
      left <= left - 1;
      if (left == 3) begin
        sysref_out <= 1'b0;
      end
    end
  end
endmodule

// ### tb/scsm_tb_top.sv
// Self-checking bench of the capture monitor over AHB-Lite.
// Assumes hreadyout feeds hready and the pin model above drives the reference pin.
`timescale 1ns/1ps
`include "scsm_cfg.svh"
module scsm_tb_top;
  logic ref_clk = 1'b0, resetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, fire = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd, hrdata;
  logic [7:0] sh_win = 8'h00;
  logic [3:0] hi_len = 4'h2;
  logic [13:0] sample = 14'h0;
  logic [14:0] word_out;
  logic hreadyout, hresp, sysref, div_reset, link_down, sigmon_sync;
  int err_count = 0, checks = 0, n_div = 0, n_link = 0, n_mon = 0;
  int t_div, t_tag, t0, side, l0;
  int dly[4] = '{0, 1, 2, 127};

  initial forever #20 ref_clk = ~ref_clk;

  always @(posedge ref_clk) begin
    sample <= sample + 14'h1;
    n_div <= n_div + int'(div_reset === 1'b1);
    n_link <= n_link + int'(link_down === 1'b1);
    n_mon <= n_mon + int'(sigmon_sync === 1'b1);
  end

  scsm_top dut (.ref_clk(ref_clk), .resetn(resetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .sysref_in(sysref),
    .sh_window_in(sh_win), .sample_in(sample), .word_out(word_out),
    .div_reset(div_reset), .link_down(link_down), .sigmon_sync(sigmon_sync));

  scsm_sref_gen gen (.ref_clk(ref_clk), .fire(fire), .hi_len(hi_len), .sysref_out(sysref));

  // ----------------------------------------
  // Checking and closing
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %0t register got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_t(input int got, input int exp);
    checks++;
    if (got != exp) begin
      err_count++;
      $display("BAD %0t count got %0d expected %0d", $time, got, exp);
    end
  endtask

  task automatic conclude();
    $display("checks %0d err_count %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge ref_clk);
    err_count++;
    conclude();
  end

  // ----------------------------------------
  // Bus and event tasks
  // ----------------------------------------
  task automatic bus(input logic wr, input logic [8:0] idx, input logic [31:0] wd);
    int n;
    n = 0;
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {21'h0, idx, 2'h0};
    @(posedge ref_clk);
    while (hreadyout !== 1'b1 && n < 50) begin
      @(posedge ref_clk);
      n++;
    end
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge ref_clk);
    while (hreadyout !== 1'b1 && n < 50) begin
      @(posedge ref_clk);
      n++;
    end
    rd = hrdata;
    chk_t(n, 0);
    // Idle cycle keeps a read clear of the preceding write
    @(posedge ref_clk);
  endtask

  task automatic rchk(input logic [8:0] idx, input logic [31:0] exp);
    bus(1'b0, idx, 32'h0);
    chk(rd, exp);
  endtask

  // Fires one pin pulse and records when div_reset and the tag first show
  task automatic ev(input int span);
    t_div = -1;
    t_tag = -1;
    fire <= 1'b1;
    @(posedge ref_clk);
    fire <= 1'b0;
    for (int i = 1; i <= span; i++) begin
      @(posedge ref_clk);
      if (div_reset === 1'b1 && t_div < 0) t_div = i;
      if (word_out[14] === 1'b1 && t_tag < 0) t_tag = i;
    end
  endtask

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    repeat (3) @(posedge ref_clk);
    resetn <= 1'b1;
    @(posedge ref_clk);
    rchk(`SCSM_IDX_SH_STAT, 32'h0);
    rchk(`SCSM_IDX_PH_STAT, 32'h0);
    rchk(`SCSM_IDX_EVT_CNT, 32'h0);
    rchk(`SCSM_IDX_SYNC, 32'h0);
    rchk(`SCSM_IDX_CTRL4, 32'h0);
    bus(1'b1, 9'h100, 32'hffff_ffff);
    rchk(9'h100, 32'h0);
    bus(1'b1, `SCSM_IDX_SH_STAT, 32'hff);
    rchk(`SCSM_IDX_SH_STAT, 32'h0);
    bus(1'b1, `SCSM_IDX_SYNC, 32'hff);
    rchk(`SCSM_IDX_SYNC, 32'h1);
    bus(1'b1, `SCSM_IDX_CTRL4, 32'hff);
    rchk(`SCSM_IDX_CTRL4, 32'h7f);
    bus(1'b1, `SCSM_IDX_CTRL4, 32'h0);
    bus(1'b1, `SCSM_IDX_SYNC, 32'h0);
    ev(20);
    chk_t(t_div, -1);
    sh_win <= 8'ha5;
    bus(1'b1, `SCSM_IDX_CTRL1, 32'h2);
    ev(20);
    t0 = t_div;
    chk_t(t_tag, -1);
    chk_t(n_div, 1);
    bus(1'b1, `SCSM_IDX_CTRL1, 32'h0);
    rchk(`SCSM_IDX_SH_STAT, 32'ha5);
    bus(1'b0, `SCSM_IDX_PH_STAT, 32'h0);
    chk(rd & 32'hffff_fff1, 32'h0);
    rchk(`SCSM_IDX_EVT_CNT, 32'h1);
    sh_win <= 8'h3c;
    hi_len <= 4'h9;
    bus(1'b1, `SCSM_IDX_CTRL1, 32'h2);
    ev(24);
    chk_t(t_div, t0);
    bus(1'b1, `SCSM_IDX_CTRL1, 32'h0);
    rchk(`SCSM_IDX_SH_STAT, 32'h3c);
    rchk(`SCSM_IDX_EVT_CNT, 32'h2);
    hi_len <= 4'h2;
    bus(1'b1, `SCSM_IDX_CTRL1, 32'h40);
    rchk(`SCSM_IDX_EVT_CNT, 32'h0);
    bus(1'b1, `SCSM_IDX_CTRL1, 32'h42);
    ev(12);
    bus(1'b1, `SCSM_IDX_CTRL1, 32'h0);
    rchk(`SCSM_IDX_EVT_CNT, 32'h0);
    bus(1'b1, `SCSM_IDX_CTRL1, 32'h2);
    repeat (253) ev(10);
    l0 = n_link;
    // Eleven cycles apart the divider phase moves, eight cycles apart it stays
    ev(7);
    ev(10);
    chk_t(n_link - l0, 1);
    bus(1'b1, `SCSM_IDX_CTRL1, 32'h0);
    rchk(`SCSM_IDX_EVT_CNT, 32'hff);
    rchk(`SCSM_IDX_PH_STAT, 32'h0);
    bus(1'b1, `SCSM_IDX_CTRL1, 32'h2);
    ev(10);
    bus(1'b1, `SCSM_IDX_CTRL1, 32'h0);
    rchk(`SCSM_IDX_EVT_CNT, 32'h0);
    chk_t(n_mon, n_div);
    // Timestamp mode: tag lands delay cycles after the sync-mode divider reset
    bus(1'b1, `SCSM_IDX_SYNC, 32'h1);
    bus(1'b1, `SCSM_IDX_CTRL1, 32'h2);
    side = n_div + n_link + n_mon;
    foreach (dly[k]) begin
      bus(1'b1, `SCSM_IDX_CTRL4, 32'(dly[k]));
      ev(160);
      chk_t(t_tag, t0 + dly[k]);
    end
    chk_t(n_div + n_link + n_mon, side);
    conclude();
  end
endmodule
